// [rtcaw_pkg.sv]
/*
  Constants shared by the alarm, watchdog and output-pin logic of the real-time clock:
  register offsets, field positions, power-on values and oscillator-derived counts.
  Assumes a 32,768 Hz oscillator whose divided ticks drive every slow timer.
*/
package rtcaw_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int DIV_W = 15;
  // Register offsets.
  localparam logic [7:0] A_SECONDS = 8'h01;
  localparam logic [7:0] A_CENT_HOURS = 8'h03;
  localparam logic [7:0] A_CAL_OUT = 8'h08;
  localparam logic [7:0] A_WDOG = 8'h09;
  localparam logic [7:0] A_AL_MONTH = 8'h0a;
  localparam logic [7:0] A_AL_DATE = 8'h0b;
  localparam logic [7:0] A_AL_HOUR = 8'h0c;
  localparam logic [7:0] A_AL_MIN = 8'h0d;
  localparam logic [7:0] A_AL_SEC = 8'h0e;
  localparam logic [7:0] A_FLAGS = 8'h0f;
  localparam logic [7:0] A_SQW_SEL = 8'h13;
  // Flag bit positions.
  localparam int F_WDF = 7;
  localparam int F_AF = 6;
  localparam int F_BL = 4;
  localparam int F_OF = 2;
  // Repeat codes, ordered ALARM_REPEAT_BITS.
  localparam logic [4:0] RPT_SEC = 5'h1f;
  localparam logic [4:0] RPT_MIN = 5'h1e;
  localparam logic [4:0] RPT_HOUR = 5'h1c;
  localparam logic [4:0] RPT_DAY = 5'h18;
  localparam logic [4:0] RPT_MONTH = 5'h10;
  localparam logic [4:0] RPT_YEAR = 5'h00;
  // Power-on values.
  localparam logic [7:0] WDOG_RST = 8'h00;
  localparam logic [7:0] CAL_RST = 8'h80;
  // Oscillator counts: 1/16 s is 2048 cycles, 512 Hz is divider bit 5.
  localparam int OSC_HZ = 32768;
  localparam int SIXTEENTH_CYC = OSC_HZ / 16;
  localparam int FT_BIT = 5;
  localparam int BATT_PERIOD_S = 86400;
  localparam int WD_CNT_W = 11;
endpackage : rtcaw_pkg

// [rtcaw_tick_if.sv]
/*
  Oscillator-derived timing that the prescaler hands to the watchdog and the top.
  Assumes all members are on clk_i; ticks are one-cycle pulses.
*/
`timescale 1ns/1ps
interface rtcaw_tick_if;
  logic osc_stop;
  logic osc_lvl;
  logic [rtcaw_pkg::DIV_W-1:0] div;
  logic tick16;
  logic tick1hz;
  modport src (input osc_stop, output osc_lvl, output div, output tick16, output tick1hz);
  modport snk (output osc_stop, input osc_lvl, input div, input tick16, input tick1hz);
  modport wdog (input tick16);
endinterface : rtcaw_tick_if

// [rtcaw_prescaler.sv]
/*
  Samples the 32,768 Hz oscillator pin, finds its rising edges and divides it.
  Assumes clk_i runs well above twice the oscillator rate.
*/
`timescale 1ns/1ps
module rtcaw_prescaler (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic resetn_i,
  // Oscillator pin and timing out.
  input wire logic osc_clk_i,
  rtcaw_tick_if.src tk
);
  import rtcaw_pkg::*;
  logic [1:0] sync_r;
  logic lvl_r;
  logic [DIV_W-1:0] div_r;
  logic edge_w;

  // Two flip-flops before anything looks at the pin.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sync_r <= 2'h0;
      lvl_r <= 1'b0;
    end else begin
      sync_r <= {sync_r[0], osc_clk_i};
      lvl_r <= sync_r[1];
    end
  end
  assign edge_w = sync_r[1] & ~lvl_r & ~tk.osc_stop;

  // A stopped oscillator freezes the divider, so every slow timer halts too.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) div_r <= '0;
    else if (edge_w) div_r <= div_r + 1'b1;
  end

  assign tk.osc_lvl = lvl_r & ~tk.osc_stop;
  assign tk.div = div_r;
  assign tk.tick16 = edge_w && (div_r[10:0] == 11'(SIXTEENTH_CYC - 1));
  assign tk.tick1hz = edge_w && (&div_r);
endmodule // rtcaw_prescaler

// [rtcaw_watchdog.sv]
/*
  Watchdog counter in sixteenths of a second.
  Assumes restart_i pulses on every write of the watchdog register.
*/
`timescale 1ns/1ps
module rtcaw_watchdog (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic resetn_i,
  // Ticks and configuration.
  rtcaw_tick_if.wdog tk,
  input wire logic [4:0] mult_i,
  input wire logic [1:0] res_i,
  input wire logic restart_i,
  // Expiry pulse.
  output logic expire_o
);
  import rtcaw_pkg::*;
  logic [WD_CNT_W-1:0] cnt_r;
  logic done_r;
  logic [WD_CNT_W-1:0] limit_w;

  // Resolution codes scale by 1, 4, 16 or 64 sixteenths.
  assign limit_w = WD_CNT_W'(mult_i) << {res_i, 1'b0};

  // A restart zeroes the count; after expiry it waits for the next write.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_r <= '0;
      done_r <= 1'b0;
      expire_o <= 1'b0;
    end else begin
      expire_o <= 1'b0;
      if (restart_i) begin
        cnt_r <= '0;
        done_r <= 1'b0;
      end else if (tk.tick16 && !done_r && mult_i != 5'h0_0) begin
        if (cnt_r + 1'b1 == limit_w) begin
          done_r <= 1'b1;
          expire_o <= 1'b1;
        end
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end
endmodule // rtcaw_watchdog

// [rtcaw_top.sv]
/*
  Alarm, watchdog, square wave, century, battery-low and oscillator-fail logic of the
  clock, with the shared open-drain output pin. Assumes the serial engine drives the
  plain register port and the time counters supply BCD time with a per-second pulse.
*/
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
module rtcaw_top #(
  parameter int BATT_PERIOD = rtcaw_pkg::BATT_PERIOD_S
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic resetn_i,
  // Register port.
  input wire logic [rtcaw_pkg::ADDR_W-1:0] addr_i,
  input wire logic [rtcaw_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [rtcaw_pkg::DATA_W-1:0] rdata_o,
  // Current time from the counters, same clock.
  input wire logic [6:0] time_sec_i,
  input wire logic [6:0] time_min_i,
  input wire logic [5:0] time_hour_i,
  input wire logic [5:0] time_date_i,
  input wire logic [4:0] time_month_i,
  input wire logic sec_tick_i,
  input wire logic century_roll_i,
  // Asynchronous status inputs and oscillator pin.
  input wire logic osc_clk_i,
  input wire logic battery_backup_i,
  input wire logic battery_low_i,
  input wire logic osc_fault_i,
  // Open-drain pin and status outputs.
  output logic multi_function_pin_n_o,
  output logic multi_function_pin_oe_n_o,
  output logic halt_update_o,
  output logic oscillator_stop_o
);
  import rtcaw_pkg::*;

  rtcaw_tick_if tk();

  // Control registers.
  logic oscillator_stop_r;
  logic century_toggle_enable_r;
  logic century_flag_r;
  logic [7:0] cal_r;
  logic [7:0] wdog_r;
  logic alarm_interrupt_enable_r;
  logic square_wave_enable_r;
  logic backup_alarm_enable_r;
  logic [4:0] al_month_r;
  logic [5:0] al_date_r;
  logic [5:0] al_hour_r;
  logic [6:0] al_min_r;
  logic [6:0] al_sec_r;
  logic [4:0] alarm_repeat_bits_r;
  logic halt_update_r;
  logic [3:0] square_freq_select_r;
  // Status flags and pin state.
  logic watchdog_expired_flag_r;
  logic alarm_match_flag_r;
  logic battery_low_flag_r;
  logic oscillator_fail_flag_r;
  logic oscillator_fail_interrupt_enable_r;
  logic alarm_pend_r;
  logic alarm_pin_r;
  logic wd_pin_r;
  logic [7:0] ptr_r;
  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  logic [$clog2(BATT_PERIOD+1)-1:0] batt_cnt_r;
  logic [7:0] rdata_nxt;
  logic wd_expire_w;
  logic alarm_hit_w;
  logic sqw_w;
  logic pin_low_nxt;
  logic wr_w;
  logic rd_flags_w;

  // Decode a write or read to one offset.
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  // Alarm comparison for a repeat code; unknown codes fall to every second.
  function automatic logic alarm_match(input logic [4:0] rpt, input logic [4:0] eq);
    logic r;
    r = 1'b1;
    case (rpt)
      RPT_MIN: r = eq[0];
      RPT_HOUR: r = &eq[1:0];
      RPT_DAY: r = &eq[2:0];
      RPT_MONTH: r = &eq[3:0];
      RPT_YEAR: r = &eq;
      default: r = 1'b1;
    endcase
    return r;
  endfunction

  rtcaw_prescaler u_presc (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .osc_clk_i(osc_clk_i),
    .tk(tk.src)
  );

  rtcaw_watchdog u_wdog (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .tk(tk.wdog),
    .mult_i(wdog_r[6:2]),
    .res_i(wdog_r[1:0]),
    .restart_i(wr_i && hit(addr_i, A_WDOG)),
    .expire_o(wd_expire_w)
  );

  assign tk.osc_stop = oscillator_stop_r;
  assign wr_w = wr_i;
  assign rd_flags_w = rd_i && hit(addr_i, A_FLAGS);

  // Battery backup, battery comparator and oscillator fault pass two flip-flops.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sync1_r <= 3'h0;
      sync2_r <= 3'h0;
    end else begin
      sync1_r <= {osc_fault_i, battery_low_i, battery_backup_i};
      sync2_r <= sync1_r;
    end
  end

  // The serial pointer moves one past every access, as auto-increment does.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) ptr_r <= 8'h00;
    else if (wr_i || rd_i) ptr_r <= addr_i + 8'h01;
  end

  // Stop, century and halt bits; reset is the initial power application.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      oscillator_stop_r <= 1'b1;
      century_toggle_enable_r <= 1'b0;
      century_flag_r <= 1'b0;
      halt_update_r <= 1'b1;
    end else begin
      if (wr_w && hit(addr_i, A_SECONDS)) oscillator_stop_r <= wdata_i[7];
      if (wr_w && hit(addr_i, A_CENT_HOURS)) century_toggle_enable_r <= wdata_i[7];
      if (wr_w && hit(addr_i, A_AL_HOUR)) halt_update_r <= wdata_i[6];
      // A rollover in the same cycle as a write toggles the written value.
      if (century_roll_i && century_toggle_enable_r) begin
        century_flag_r <= ~((wr_w && hit(addr_i, A_CENT_HOURS)) ? wdata_i[6] :
          century_flag_r);
      end else if (wr_w && hit(addr_i, A_CENT_HOURS)) begin
        century_flag_r <= wdata_i[6];
      end
    end
  end

  // Output level, frequency test, calibration and square wave select.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cal_r <= CAL_RST;
      square_freq_select_r <= 4'h0;
    end else begin
      if (wr_w && hit(addr_i, A_CAL_OUT)) cal_r <= wdata_i;
      if (wr_w && hit(addr_i, A_SQW_SEL)) square_freq_select_r <= wdata_i[7:4];
    end
  end

  // Watchdog register; its top bit is the oscillator fail interrupt enable.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wdog_r <= WDOG_RST;
      oscillator_fail_interrupt_enable_r <= 1'b0;
    end else if (wr_w && hit(addr_i, A_WDOG)) begin
      wdog_r <= {1'b0, wdata_i[6:0]};
      oscillator_fail_interrupt_enable_r <= wdata_i[7];
    end
  end

  // Alarm registers with the repeat bits scattered over their top bits.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      alarm_interrupt_enable_r <= 1'b0;
      square_wave_enable_r <= 1'b0;
      backup_alarm_enable_r <= 1'b0;
      al_month_r <= 5'h0_0;
      al_date_r <= 6'h0_0;
      al_hour_r <= 6'h0_0;
      al_min_r <= 7'h0_0;
      al_sec_r <= 7'h0_0;
      alarm_repeat_bits_r <= 5'h0_0;
    end else if (wr_w) begin
      if (hit(addr_i, A_AL_MONTH)) begin
        alarm_interrupt_enable_r <= wdata_i[7];
        square_wave_enable_r <= wdata_i[6];
        backup_alarm_enable_r <= wdata_i[5];
        al_month_r <= wdata_i[4:0];
      end else if (hit(addr_i, A_AL_DATE)) begin
        alarm_repeat_bits_r[3] <= wdata_i[7];
        alarm_repeat_bits_r[4] <= wdata_i[6];
        al_date_r <= wdata_i[5:0];
      end else if (hit(addr_i, A_AL_HOUR)) begin
        alarm_repeat_bits_r[2] <= wdata_i[7];
        al_hour_r <= wdata_i[5:0];
      end else if (hit(addr_i, A_AL_MIN)) begin
        alarm_repeat_bits_r[1] <= wdata_i[7];
        al_min_r <= wdata_i[6:0];
      end else if (hit(addr_i, A_AL_SEC)) begin
        alarm_repeat_bits_r[0] <= wdata_i[7];
        al_sec_r <= wdata_i[6:0];
      end
    end
  end

  // Match is evaluated once per second on the freshly counted time.
  assign alarm_hit_w = sec_tick_i && alarm_match(alarm_repeat_bits_r, {
    time_month_i == al_month_r, time_date_i == al_date_r, time_hour_i == al_hour_r,
    time_min_i == al_min_r, time_sec_i == al_sec_r});

  // Alarm flag and pin request; a new match beats a flags read in the same cycle.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      alarm_match_flag_r <= 1'b0;
      alarm_pend_r <= 1'b0;
      alarm_pin_r <= 1'b0;
    end else begin
      if (alarm_hit_w) alarm_match_flag_r <= 1'b1;
      else if (rd_flags_w) alarm_match_flag_r <= 1'b0;
      if (alarm_hit_w) alarm_pend_r <= 1'b1;
      else if (rd_flags_w || alarm_pin_r) alarm_pend_r <= 1'b0;
      // The pin request waits while the pointer rests on the flags address.
      if (alarm_pend_r && ptr_r != A_FLAGS && !rd_flags_w) alarm_pin_r <= 1'b1;
      else if (rd_flags_w) alarm_pin_r <= 1'b0;
    end
  end

  // Watchdog flag clears on a flags read; the pin holds until zero is written.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      watchdog_expired_flag_r <= 1'b0;
      wd_pin_r <= 1'b0;
    end else begin
      if (wd_expire_w) watchdog_expired_flag_r <= 1'b1;
      else if (rd_flags_w) watchdog_expired_flag_r <= 1'b0;
      if (wd_expire_w) wd_pin_r <= 1'b1;
      else if (wr_w && hit(addr_i, A_WDOG) && wdata_i == 8'h00) wd_pin_r <= 1'b0;
    end
  end

  // Oscillator fail: set wins over the host writing zero.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) oscillator_fail_flag_r <= 1'b1;
    else if (oscillator_stop_r || sync2_r[2]) oscillator_fail_flag_r <= 1'b1;
    else if (wr_w && hit(addr_i, A_FLAGS) && !wdata_i[F_OF]) begin
      oscillator_fail_flag_r <= 1'b0;
    end
  end

  // The first test runs one second after the stop bit is first cleared, then once a period.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      batt_cnt_r <= '0;
      battery_low_flag_r <= 1'b0;
    end else if (tk.tick1hz && !sync2_r[0]) begin
      if (batt_cnt_r == '0) begin
        battery_low_flag_r <= sync2_r[1];
        batt_cnt_r <= ($bits(batt_cnt_r))'(BATT_PERIOD - 1);
      end else begin
        batt_cnt_r <= batt_cnt_r - 1'b1;
      end
    end
  end

  // Square wave: code 1 is the oscillator itself, code n is divider bit n-1.
  always_comb begin
    sqw_w = 1'b1;
    if (square_freq_select_r == 4'h1) sqw_w = tk.osc_lvl;
    else if (square_freq_select_r != 4'h0) sqw_w = tk.div[square_freq_select_r - 4'h1];
  end

  // Pin arbitration; square wave, then alarm or watchdog, then frequency test, then output level own the pin; the shared interrupts pull low in every mode.
  always_comb begin
    logic alarm_irq;
    logic shared_irq;
    alarm_irq = alarm_pin_r && alarm_interrupt_enable_r &&
      (!sync2_r[0] || backup_alarm_enable_r);
    shared_irq = wd_pin_r ||
      (oscillator_fail_flag_r && oscillator_fail_interrupt_enable_r);
    if (square_wave_enable_r) begin
      // The alarm is masked while the square wave owns the pin.
      pin_low_nxt = !sqw_w || shared_irq;
    end else if (alarm_interrupt_enable_r || wdog_r != 8'h00) begin
      pin_low_nxt = alarm_irq || shared_irq;
    end else if (cal_r[6]) begin
      pin_low_nxt = shared_irq || (!oscillator_stop_r && !tk.div[FT_BIT]);
    end else begin
      pin_low_nxt = shared_irq || !cal_r[7];
    end
  end

  // The pin is registered so glitches of the decode never reach the line.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      multi_function_pin_n_o <= 1'b0;
      multi_function_pin_oe_n_o <= 1'b1;
    end else begin
      multi_function_pin_n_o <= 1'b0;
      multi_function_pin_oe_n_o <= ~pin_low_nxt;
    end
  end

  // Read decode; unlisted offsets and time fields read as zero here.
  always_comb begin
    rdata_nxt = 8'h00;
    if (hit(addr_i, A_SECONDS)) rdata_nxt = {oscillator_stop_r, 7'h00};
    else if (hit(addr_i, A_CENT_HOURS)) begin
      rdata_nxt = {century_toggle_enable_r, century_flag_r, 6'h00};
    end else if (hit(addr_i, A_CAL_OUT)) rdata_nxt = cal_r;
    else if (hit(addr_i, A_WDOG)) begin
      rdata_nxt = {oscillator_fail_interrupt_enable_r, wdog_r[6:0]};
    end else if (hit(addr_i, A_AL_MONTH)) begin
      rdata_nxt = {alarm_interrupt_enable_r, square_wave_enable_r, backup_alarm_enable_r,
        al_month_r};
    end else if (hit(addr_i, A_AL_DATE)) begin
      rdata_nxt = {alarm_repeat_bits_r[3], alarm_repeat_bits_r[4], al_date_r};
    end else if (hit(addr_i, A_AL_HOUR)) begin
      rdata_nxt = {alarm_repeat_bits_r[2], halt_update_r, al_hour_r};
    end else if (hit(addr_i, A_AL_MIN)) rdata_nxt = {alarm_repeat_bits_r[1], al_min_r};
    else if (hit(addr_i, A_AL_SEC)) rdata_nxt = {alarm_repeat_bits_r[0], al_sec_r};
    else if (hit(addr_i, A_FLAGS)) begin
      rdata_nxt[F_WDF] = watchdog_expired_flag_r;
      rdata_nxt[F_AF] = alarm_match_flag_r;
      rdata_nxt[F_BL] = battery_low_flag_r;
      rdata_nxt[F_OF] = oscillator_fail_flag_r;
    end else if (hit(addr_i, A_SQW_SEL)) rdata_nxt = {square_freq_select_r, 4'h0};
  end

  // Read data stand only in the cycle after the strobe.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) rdata_o <= 8'h00;
    else rdata_o <= rd_i ? rdata_nxt : 8'h00;
  end

  // Status copies for the time counters.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      halt_update_o <= 1'b1;
      oscillator_stop_o <= 1'b1;
    end else begin
      halt_update_o <= halt_update_r;
      oscillator_stop_o <= oscillator_stop_r;
    end
  end
endmodule // rtcaw_top

// [rtcaw_chk.sv]
/*
  Concurrent checks on the ports of rtcaw_top, bound below.
  Assumes one clock domain on clk_i with resetn_i as its reset.
*/
`timescale 1ns/1ps
module rtcaw_chk #(
  parameter int BATT_PERIOD = rtcaw_pkg::BATT_PERIOD_S
) (
  // Clock, reset and register port.
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [rtcaw_pkg::ADDR_W-1:0] addr_i,
  input wire logic [rtcaw_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [rtcaw_pkg::DATA_W-1:0] rdata_o,
  // Time pulse and outputs.
  input wire logic sec_tick_i,
  input wire logic multi_function_pin_n_o,
  input wire logic multi_function_pin_oe_n_o,
  input wire logic halt_update_o,
  input wire logic oscillator_stop_o
);
  import rtcaw_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  logic [7:0] wd_r;
  logic [3:0] sq_r;
  wire rdf = rd_i && addr_i == A_FLAGS;
  // Shadow of the watchdog byte, so read-back is judged against what was written.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) wd_r <= 8'h00;
    else if (wr_i && addr_i == A_WDOG) wd_r <= wdata_i;
  end
  // Shadow of the square select field.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) sq_r <= 4'h0;
    else if (wr_i && addr_i == A_SQW_SEL) sq_r <= wdata_i[7:4];
  end
  pin_data_a: assert property (multi_function_pin_n_o == 1'b0)
    else $error("pin data not low");
  af_reread_a: assert property ((rdf && !sec_tick_i) ##1 !sec_tick_i ##1
    (rdf && !sec_tick_i) |=> !rdata_o[F_AF]) else $error("alarm flag seen twice");
  stop_copy_a: assert property (wr_i && addr_i == A_SECONDS |=> ##1
    oscillator_stop_o == $past(wdata_i[7], 2)) else $error("stop copy wrong");
  halt_copy_a: assert property (wr_i && addr_i == A_AL_HOUR |=> ##1
    halt_update_o == $past(wdata_i[6], 2)) else $error("halt copy wrong");
  of_stop_a: assert property (rdf && oscillator_stop_o && $past(oscillator_stop_o)
    |=> rdata_o[F_OF]) else $error("fail flag clear while stopped");
  flags_rsvd_a: assert property (rdf |=> (rdata_o & 8'h2b) == 8'h00)
    else $error("flags spare bits set");
  wd_readback_a: assert property (rd_i && addr_i == A_WDOG |=> rdata_o == wd_r)
    else $error("watchdog readback wrong");
  sqw_readback_a: assert property (rd_i && addr_i == A_SQW_SEL |=>
    rdata_o == {sq_r, 4'h0}) else $error("square select readback wrong");
  // Main scenarios reached.
  cover property (rdf ##1 rdata_o[F_AF]);
  cover property (rdf ##1 rdata_o[F_WDF]);
  cover property ($fell(multi_function_pin_oe_n_o));
endmodule // rtcaw_chk
bind rtcaw_top rtcaw_chk #(.BATT_PERIOD(BATT_PERIOD)) rtcaw_chk_i (.clk_i, .resetn_i,
  .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .sec_tick_i, .multi_function_pin_n_o,
  .multi_function_pin_oe_n_o, .halt_update_o, .oscillator_stop_o);

// [rtcaw_host.sv]
/*
  Host model on the register port: single-byte writes and reads.
  Assumes read data stand only in the cycle after the read strobe.
*/
`timescale 1ns/1ps
module rtcaw_host (
  // Clock.
  input wire logic clk_i,
  // Register port.
  input wire logic [rtcaw_pkg::DATA_W-1:0] rdata_i,
  output logic [rtcaw_pkg::ADDR_W-1:0] addr_o,
  output logic [rtcaw_pkg::DATA_W-1:0] wdata_o,
  output logic wr_o,
  output logic rd_o
);
  import rtcaw_pkg::*;
  // Idle bus before the first transfer.
  initial begin
    addr_o = 8'h00;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  // Released lines show the inverse, so stale values cannot pass for fresh ones.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask
  // Read data are taken once the answering edge has settled.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    #1;
    d = rdata_i;
  endtask
  // Restart after an oscillator failure: stop set, then cleared at once.
  task automatic osc_restart;
    wr(A_SECONDS, 8'h80);
    wr(A_SECONDS, 8'h00);
  endtask
endmodule // rtcaw_host

// [rtcaw_top_tb_top.sv]
/*
  Self-checking bench for rtcaw_top with oscillator and time stimulus.
  Assumes the host model drives the register port and the checker is bound.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_count++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module rtcaw_top_tb_top;
  import rtcaw_pkg::*;
  logic clk_i = 0, resetn_i = 0, osc_clk_i = 0, battery_backup_i = 0, battery_low_i = 0;
  logic osc_fault_i = 0, century_roll_i = 0, sec_tick_i = 0, wr_i, rd_i;
  logic [6:0] time_sec_i = 0, time_min_i = 0;
  logic [5:0] time_hour_i = 0, time_date_i = 0;
  logic [4:0] time_month_i = 0;
  logic [7:0] addr_i, wdata_i, rdata_o, d, seed = 8'h48;
  logic multi_function_pin_n_o, multi_function_pin_oe_n_o, halt_update_o, oscillator_stop_o;
  logic [15:0] rst_t [5] = '{16'h0900, 16'h0880, 16'h0a00, 16'h0f04, 16'h1000};
  // Hour, day and month modes meet a non-zero random minute, so they must not match.
  logic [9:0] al [10] = '{10'h3e3, 10'h1e3, 10'h3c0, 10'h3d3, 10'h000, 10'h390, 10'h310,
    10'h210, 10'h3e6, 10'h3ef};
  int err_count = 0, num_checks = 0, cyc = 0, n, e;
  wire oen = multi_function_pin_oe_n_o;
  rtcaw_top #(.BATT_PERIOD(3)) rtcaw_top_i (.*);
  rtcaw_host rtcaw_host_i (.clk_i, .rdata_i(rdata_o), .addr_o(addr_i), .wdata_o(wdata_i),
    .wr_o(wr_i), .rd_o(rd_i));
  // Clocks; the oscillator is offset so its edges never coincide with a clk_i edge.
  always #50 clk_i = ~clk_i;
  initial begin
    #137;
    forever #400 osc_clk_i = ~osc_clk_i;
  end
  // A hang counts as a mismatch.
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 80000) begin
      err_count++;
      tally_and_finish();
    end
  end
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic pause(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask
  // New second with random time fields beside the chosen seconds.
  task automatic tick(input logic [6:0] s);
    @(posedge clk_i);
    seed = lfsr(seed);
    time_sec_i <= s;
    time_min_i <= seed[6:0];
    time_hour_i <= seed[5:0];
    time_date_i <= seed[5:0];
    time_month_i <= seed[4:0];
    sec_tick_i <= 1'b1;
    @(posedge clk_i);
    sec_tick_i <= 1'b0;
  endtask
  // Counts pin changes over a window of cycles.
  task automatic edges(input int w, output int c);
    logic p;
    p = oen;
    c = 0;
    repeat (w) begin
      @(posedge clk_i);
      #1;
      if (oen !== p) c++;
      p = oen;
    end
  endtask
  // Alarm at seconds 30 with the month register written last, off the flags address.
  task automatic set_alarm(input logic [4:0] c, input logic [1:0] m);
    rtcaw_host_i.wr(A_AL_DATE, {c[3], c[4], 6'h00});
    rtcaw_host_i.wr(A_AL_HOUR, {c[2], 7'h00});
    rtcaw_host_i.wr(A_AL_MIN, {c[1], 7'h00});
    rtcaw_host_i.wr(A_AL_SEC, {c[0], 7'h30});
    battery_backup_i <= m[0];
    rtcaw_host_i.wr(A_AL_MONTH, {2'b10, m[1], 5'h00});
  endtask
  task automatic tally_and_finish;
    if (err_count == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk_i);
    resetn_i <= 1'b1;
    pause(1);
    `CHK({oen, halt_update_o, oscillator_stop_o}, 3'b111)
    foreach (rst_t[k]) begin
      rtcaw_host_i.rd(rst_t[k][15:8], d);
      `CHK(d, rst_t[k][7:0])
    end
    rtcaw_host_i.wr(A_CAL_OUT, {2'b00, seed[5:0]});
    pause(2);
    `CHK(oen, 1'b0)
    rtcaw_host_i.rd(A_CAL_OUT, d);
    `CHK(d, {2'b00, seed[5:0]})
    rtcaw_host_i.wr(A_CAL_OUT, 8'h80);
    pause(2);
    `CHK(oen, 1'b1)
    rtcaw_host_i.wr(A_FLAGS, 8'h00);
    rtcaw_host_i.rd(A_FLAGS, d);
    `CHK(d[F_OF], 1'b1)
    rtcaw_host_i.osc_restart();
    rtcaw_host_i.wr(A_FLAGS, 8'h00);
    rtcaw_host_i.rd(A_FLAGS, d);
    `CHK(d[F_OF], 1'b0)
    foreach (al[k]) begin
      set_alarm(al[k][9:5], al[k][3:2]);
      tick(al[k][4] ? 7'h30 : 7'h31);
      pause(4);
      `CHK(oen, ~al[k][0])
      rtcaw_host_i.rd(A_FLAGS, d);
      `CHK(d[F_AF], al[k][1])
      pause(3);
    end
    @(posedge clk_i) battery_backup_i <= 1'b0;
    tick(7'h30);
    pause(4);
    `CHK(oen, 1'b0)
    rtcaw_host_i.rd(A_FLAGS, d);
    rtcaw_host_i.rd(A_FLAGS, d);
    `CHK({oen, d[F_AF]}, 2'b10)
    rtcaw_host_i.rd(A_AL_SEC, d);
    tick(7'h30);
    pause(4);
    `CHK(oen, 1'b1)
    rtcaw_host_i.rd(A_SECONDS, d);
    pause(3);
    `CHK(oen, 1'b0)
    rtcaw_host_i.rd(A_FLAGS, d);
    rtcaw_host_i.wr(A_AL_MONTH, 8'h00);
    rtcaw_host_i.wr(A_WDOG, 8'h80);
    @(posedge clk_i) osc_fault_i <= 1'b1;
    @(posedge clk_i) osc_fault_i <= 1'b0;
    pause(6);
    `CHK(oen, 1'b0)
    rtcaw_host_i.rd(A_FLAGS, d);
    pause(2);
    `CHK({oen, d[F_OF]}, 2'b01)
    rtcaw_host_i.wr(A_FLAGS, 8'h00);
    pause(2);
    `CHK(oen, 1'b1)
    rtcaw_host_i.wr(A_WDOG, 8'h00);
    rtcaw_host_i.wr(A_CAL_OUT, 8'hc0);
    edges(1024, n);
    `CHK(n >= 3 && n <= 5, 1'b1)
    rtcaw_host_i.wr(A_AL_MONTH, 8'h40);
    // Code 1 is the oscillator itself: 256 pin changes in 1024 cycles on this bench.
    for (int c = 0; c < 7; c++) begin
      rtcaw_host_i.wr(A_SQW_SEL, {c[3:0], 4'h0});
      rtcaw_host_i.rd(A_SQW_SEL, d);
      edges(1024, n);
      e = (c == 1) ? 256 : (c ? 256 >> c : 0);
      `CHK(n + 1 >= e && n <= e + 1, 1'b1)
    end
    rtcaw_host_i.wr(A_AL_MONTH, 8'h00);
    rtcaw_host_i.wr(A_WDOG, 8'h08);
    pause(2);
    edges(12000, n);
    `CHK(n, 0)
    rtcaw_host_i.wr(A_WDOG, 8'h08);
    pause(2);
    edges(16000, n);
    `CHK({n == 0, oen}, 2'b11)
    n = 0;
    while (oen !== 1'b0 && n < 17000) begin
      pause(1);
      n++;
    end
    `CHK(oen, 1'b0)
    rtcaw_host_i.rd(A_FLAGS, d);
    `CHK(d[F_WDF], 1'b1)
    rtcaw_host_i.rd(A_FLAGS, d);
    `CHK({oen, d[F_WDF]}, 2'b00)
    rtcaw_host_i.wr(A_CAL_OUT, 8'h80);
    rtcaw_host_i.wr(A_WDOG, 8'h00);
    pause(2);
    `CHK(oen, 1'b1)
    for (int b = 1; b >= 0; b--) begin
      rtcaw_host_i.wr(A_CENT_HOURS, {b[0], 7'h00});
      @(posedge clk_i) century_roll_i <= 1'b1;
      @(posedge clk_i) century_roll_i <= 1'b0;
      rtcaw_host_i.rd(A_CENT_HOURS, d);
      `CHK(d, {b[0], b[0], 6'h00})
    end
    tally_and_finish();
  end
endmodule // rtcaw_top_tb_top
